//--- core/lmt_top.sv
/*
 * Legacy mixer translator: indirect mixer port, volume translation, codec write issue.
 * Assumes the host strobes are synchronous to CORE_CLK and the codec engine holds READY.
 */
// Overview of operation
// R1: Codec select bit picks primary or secondary.
// R2: Line-out disable skips codec register 02h.
// R3: Alternate disable skips codec register 04h.
// R4: Mono disable skips codec register 06h.
// R5: Master write reaches every enabled master output.
// R6: Master left 7:5, right 3:1 to 02/04; 06 takes left 7:5 only.
// R7: Voice levels drive internal playback registers.
// R8: Synth levels drive internal FM registers premix.
// R9: Disc levels go to codec register 12h.
// R10: Line levels go to codec register 10h.
// R11: Input select goes to record select 1Ah.
// R12: Select codes map mic, disc, mic, line.
// R13: Record volume follows the selected source.
// R14: Readback returns stored, last, 11h or FFh.
// R15: Index bits 0 and 4 are ignored.
// R16: Both levels zero sets the mute bit.
// R17: One zero level gets maximum attenuation.
// R18: Levels translate through lookup tables.
// R19: Legacy samples are eight bits only.
// R20: First stereo byte right, second left.
// R21: Host clears hold-sample flag before legacy mode.
// R22: Host sets codec DAC volume to 0 dB.
// R23: Multiple codec writes queue, issued one each.
// R24: Host writes index, then accesses value port.
`timescale 1ns/100ps
module lmt_top
    import lmt_pkg::*;
#(
    parameter logic [6:0] REC_VOL_REG = 7'h1C
)
(
    input  wire logic          CORE_CLK,
    input  wire logic          RESET,
    input  wire logic          INDEX_WR,
    input  wire logic          VALUE_WR,
    input  wire logic          VALUE_RD,
    input  wire logic [7:0]    WDATA,
    output logic      [7:0]    RDATA,
    output logic      [7:0]    INDEX,
    input  wire logic          CODEC_SELECT,
    input  wire logic          LINEOUT_UPDATE_DISABLE,
    input  wire logic          ALT_OUT_UPDATE_DISABLE,
    input  wire logic          MONO_OUT_UPDATE_DISABLE,
    output logic               CODEC_WR_VALID,
    input  wire logic          CODEC_WR_READY,
    output lmt_codec_wr_t      CODEC_WR,
    output lmt_level_pair_t    PLAYBACK_LEVEL,
    output lmt_level_pair_t    SYNTH_LEVEL,
    output logic               STEREO_OUTPUT_FLAG,
    input  wire logic          SAMPLE_IN_VALID,
    input  wire logic [7:0]    SAMPLE_IN,
    output logic               SAMPLE_OUT_VALID,
    output lmt_sample_t        SAMPLE_OUT
);

    if (REC_VOL_REG[0] != 1'b0)
        $error("REC_VOL_REG must be an even codec register index");

    function automatic logic [7:0] master_code(input logic [2:0] lvl); // R18
        case (lvl)
            3'h0: master_code = 8'h1F;
            3'h1: master_code = 8'h12;
            3'h2: master_code = 8'h0E;
            3'h3: master_code = 8'h0B;
            3'h4: master_code = 8'h08;
            3'h5: master_code = 8'h05;
            3'h6: master_code = 8'h02;
            default: master_code = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] input_code(input logic [2:0] lvl); // R18
        case (lvl)
            3'h0: input_code = 8'h1F;
            3'h1: input_code = 8'h1A;
            3'h2: input_code = 8'h16;
            3'h3: input_code = 8'h13;
            3'h4: input_code = 8'h10;
            3'h5: input_code = 8'h0D;
            3'h6: input_code = 8'h0A;
            default: input_code = 8'h08;
        endcase
    endfunction

    function automatic logic [7:0] mic_code(input logic [1:0] lvl); // R18
        case (lvl)
            2'h0: mic_code = 8'h45;
            2'h1: mic_code = 8'h49;
            2'h2: mic_code = 8'h01;
            default: mic_code = 8'h04;
        endcase
    endfunction

    // Stereo codec word; a zero level already maps to the largest attenuation code.
    function automatic logic [15:0] stereo_word(input logic [7:0] v, input logic is_master);
        logic [2:0]  l;
        logic [2:0]  r;
        logic [15:0] w;
        l = v[LEFT_HI:LEFT_LO];
        r = v[RIGHT_HI:RIGHT_LO];
        w = is_master ? {master_code(l), master_code(r)} : {input_code(l), input_code(r)}; // R17
        w[MUTE_B] = (l == 3'h0) && (r == 3'h0); // R16
        stereo_word = w;
    endfunction

    logic [7:0]            voice_level_r, mic_mix_level_r, input_source_select_r;
    logic [7:0]            output_setting_r, master_level_r, synth_level_r;
    logic [7:0]            disc_level_r, line_level_r, index_r, last_rd_r, rdata_r;
    logic [7:0]            voice_level_nxt, mic_mix_level_nxt, input_source_select_nxt;
    logic [7:0]            output_setting_nxt, master_level_nxt, synth_level_nxt;
    logic [7:0]            disc_level_nxt, line_level_nxt, index_nxt, last_rd_nxt, rdata_nxt;
    logic [PEND_N-1:0]     pend_r, pend_nxt, pend_set, pend_clr;
    lmt_link_state_t       link_r, link_nxt;
    lmt_codec_wr_t         out_r, out_nxt;
    logic [7:0]            dec_idx, rd_value;
    logic [1:0]            in_sel;
    logic [15:0]           rec_sel_word, rec_vol_word;
    logic                  half_r, half_nxt, sval_r, sval_nxt;
    lmt_sample_t           samp_r, samp_nxt;

    assign dec_idx = index_r & MIX_ALIAS_MASK; // R15
    assign in_sel  = input_source_select_r[INSEL_HI:INSEL_LO];

    always_comb
    begin
        case (in_sel) // R12
            SEL_DISC: rec_sel_word = REC_DISC;
            SEL_LINE: rec_sel_word = REC_LINE;
            default:  rec_sel_word = REC_MIC;
        endcase
        case (in_sel) // R13
            SEL_DISC: rec_vol_word = stereo_word(disc_level_r, 1'b0);
            SEL_LINE: rec_vol_word = stereo_word(line_level_r, 1'b0);
            default:  rec_vol_word = {8'h00, mic_code(mic_mix_level_r[MIC_HI:MIC_LO])};
        endcase
    end

    always_comb
    begin
        if (dec_idx >= MIX_HIGH_BASE) // R14
            rd_value = MIX_HIGH_VALUE;
        else
            case (dec_idx)
                8'h02, MIX_MASTER: rd_value = master_level_r;
                MIX_VOICE:         rd_value = voice_level_r;
                8'h06, MIX_SYNTH:  rd_value = synth_level_r;
                8'h08, MIX_DISC:   rd_value = disc_level_r;
                MIX_MIC:           rd_value = mic_mix_level_r;
                MIX_INPUT:         rd_value = input_source_select_r;
                MIX_OUTPUT:        rd_value = output_setting_r;
                MIX_ID:            rd_value = MIX_ID_VALUE;
                MIX_LINE:          rd_value = line_level_r;
                default:           rd_value = last_rd_r;
            endcase
    end

    always_comb
    begin
        voice_level_nxt         = voice_level_r;
        mic_mix_level_nxt       = mic_mix_level_r;
        input_source_select_nxt = input_source_select_r;
        output_setting_nxt      = output_setting_r;
        master_level_nxt        = master_level_r;
        synth_level_nxt         = synth_level_r;
        disc_level_nxt          = disc_level_r;
        line_level_nxt          = line_level_r;
        index_nxt               = INDEX_WR ? WDATA : index_r; // R24
        last_rd_nxt             = last_rd_r;
        rdata_nxt               = rdata_r;
        pend_set                = '0;
        if (VALUE_RD)
        begin
            rdata_nxt   = rd_value; // R14
            last_rd_nxt = rd_value;
        end
        if (VALUE_WR && !INDEX_WR)
            case (dec_idx)
                MIX_RESET_TRIGGER:
                begin
                    voice_level_nxt         = DEF_LOUD;
                    master_level_nxt        = DEF_LOUD;
                    synth_level_nxt         = DEF_LOUD;
                    mic_mix_level_nxt       = DEF_QUIET;
                    input_source_select_nxt = DEF_QUIET;
                    output_setting_nxt      = DEF_QUIET;
                    disc_level_nxt          = DEF_QUIET;
                    line_level_nxt          = DEF_QUIET;
                    pend_set                = '1;
                    pend_set[P_LINE_OUT]    = !LINEOUT_UPDATE_DISABLE;
                    pend_set[P_ALT_OUT]     = !ALT_OUT_UPDATE_DISABLE;
                    pend_set[P_MONO_OUT]    = !MONO_OUT_UPDATE_DISABLE;
                end
                MIX_VOICE:  voice_level_nxt = WDATA; // R7
                MIX_SYNTH:  synth_level_nxt = WDATA; // R8
                MIX_OUTPUT: output_setting_nxt = WDATA;
                MIX_MASTER:
                begin
                    master_level_nxt     = WDATA;
                    pend_set[P_LINE_OUT] = !LINEOUT_UPDATE_DISABLE; // R2 R5
                    pend_set[P_ALT_OUT]  = !ALT_OUT_UPDATE_DISABLE; // R3 R5
                    pend_set[P_MONO_OUT] = !MONO_OUT_UPDATE_DISABLE; // R4 R5
                end
                MIX_MIC:
                begin
                    mic_mix_level_nxt   = WDATA;
                    pend_set[P_MIC]     = 1'b1;
                    pend_set[P_REC_VOL] = 1'b1;
                end
                MIX_INPUT:
                begin
                    input_source_select_nxt = WDATA;
                    pend_set[P_REC_SEL]     = 1'b1; // R11
                    pend_set[P_REC_VOL]     = 1'b1; // R13
                end
                MIX_DISC:
                begin
                    disc_level_nxt      = WDATA;
                    pend_set[P_DISC]    = 1'b1; // R9
                    pend_set[P_REC_VOL] = 1'b1;
                end
                MIX_LINE:
                begin
                    line_level_nxt      = WDATA;
                    pend_set[P_LINE_IN] = 1'b1; // R10
                    pend_set[P_REC_VOL] = 1'b1;
                end
                default: ;
            endcase
    end

    // One codec write at a time; pending targets coalesce and are built from current values.
    always_comb
    begin
        link_nxt = link_r;
        out_nxt  = out_r;
        pend_clr = '0;
        if (link_r == LS_IDLE || CODEC_WR_READY)
        begin
            link_nxt = LS_IDLE;
            for (int i = PEND_N - 1; i >= 0; i--)
                if (pend_r[i])
                begin
                    pend_clr          = '0;
                    pend_clr[i]       = 1'b1;
                    link_nxt          = LS_BUSY;
                    out_nxt.secondary = CODEC_SELECT; // R1
                    case (i) // R23
                        P_LINE_OUT:
                        begin
                            out_nxt.reg_addr = AC_LINE_OUT;
                            out_nxt.data     = stereo_word(master_level_r, 1'b1); // R6
                        end
                        P_ALT_OUT:
                        begin
                            out_nxt.reg_addr = AC_ALT_OUT;
                            out_nxt.data     = stereo_word(master_level_r, 1'b1); // R6
                        end
                        P_MONO_OUT:
                        begin
                            out_nxt.reg_addr = AC_MONO_OUT; // R6
                            out_nxt.data     = {master_level_r[LEFT_HI:LEFT_LO] == 3'h0,
                                                7'h00,
                                                master_code(master_level_r[LEFT_HI:LEFT_LO])};
                        end
                        P_MIC:
                        begin
                            out_nxt.reg_addr = AC_MIC;
                            out_nxt.data     = {8'h00,
                                                mic_code(mic_mix_level_r[MIC_HI:MIC_LO])};
                        end
                        P_LINE_IN:
                        begin
                            out_nxt.reg_addr = AC_LINE_IN; // R10
                            out_nxt.data     = stereo_word(line_level_r, 1'b0);
                        end
                        P_DISC:
                        begin
                            out_nxt.reg_addr = AC_DISC; // R9
                            out_nxt.data     = stereo_word(disc_level_r, 1'b0);
                        end
                        P_REC_SEL:
                        begin
                            out_nxt.reg_addr = AC_REC_SEL; // R11
                            out_nxt.data     = rec_sel_word;
                        end
                        default:
                        begin
                            out_nxt.reg_addr = REC_VOL_REG; // R13
                            out_nxt.data     = rec_vol_word;
                        end
                    endcase
                end
        end
        pend_nxt = (pend_r & ~pend_clr) | pend_set;
    end

    // Legacy samples: one byte per strobe, stereo pairs arrive right first.
    always_comb
    begin
        half_nxt = half_r;
        samp_nxt = samp_r;
        sval_nxt = 1'b0;
        if (SAMPLE_IN_VALID) // R19
        begin
            if (!output_setting_r[STEREO_B])
            begin
                samp_nxt = '{left: SAMPLE_IN, right: SAMPLE_IN};
                sval_nxt = 1'b1;
                half_nxt = 1'b0;
            end
            else if (!half_r)
            begin
                samp_nxt.right = SAMPLE_IN; // R20
                half_nxt       = 1'b1;
            end
            else
            begin
                samp_nxt.left = SAMPLE_IN; // R20
                sval_nxt      = 1'b1;
                half_nxt      = 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            voice_level_r         <= DEF_LOUD;
            master_level_r        <= DEF_LOUD;
            synth_level_r         <= DEF_LOUD;
            mic_mix_level_r       <= DEF_QUIET;
            input_source_select_r <= DEF_QUIET;
            output_setting_r      <= DEF_QUIET;
            disc_level_r          <= DEF_QUIET;
            line_level_r          <= DEF_QUIET;
            index_r               <= MIX_HIGH_VALUE;
            last_rd_r             <= MIX_ID_VALUE;
            rdata_r               <= MIX_ID_VALUE;
            pend_r                <= '0;
            link_r                <= LS_IDLE;
            out_r                 <= '0;
            half_r                <= 1'b0;
            samp_r                <= '0;
            sval_r                <= 1'b0;
        end
        else
        begin
            voice_level_r         <= voice_level_nxt;
            master_level_r        <= master_level_nxt;
            synth_level_r         <= synth_level_nxt;
            mic_mix_level_r       <= mic_mix_level_nxt;
            input_source_select_r <= input_source_select_nxt;
            output_setting_r      <= output_setting_nxt;
            disc_level_r          <= disc_level_nxt;
            line_level_r          <= line_level_nxt;
            index_r               <= index_nxt;
            last_rd_r             <= last_rd_nxt;
            rdata_r               <= rdata_nxt;
            pend_r                <= pend_nxt;
            link_r                <= link_nxt;
            out_r                 <= out_nxt;
            half_r                <= half_nxt;
            samp_r                <= samp_nxt;
            sval_r                <= sval_nxt;
        end
    end

    assign RDATA              = rdata_r;
    assign INDEX              = index_r;
    assign CODEC_WR_VALID     = (link_r == LS_BUSY);
    assign CODEC_WR           = out_r;
    assign PLAYBACK_LEVEL     = '{left:  voice_level_r[LEFT_HI:LEFT_LO],
                                  right: voice_level_r[RIGHT_HI:RIGHT_LO]}; // R7
    assign SYNTH_LEVEL        = '{left:  synth_level_r[LEFT_HI:LEFT_LO],
                                  right: synth_level_r[RIGHT_HI:RIGHT_LO]}; // R8
    assign STEREO_OUTPUT_FLAG = output_setting_r[STEREO_B];
    assign SAMPLE_OUT_VALID   = sval_r;
    assign SAMPLE_OUT         = samp_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    sequence s_master_wr;
        VALUE_WR && !INDEX_WR && dec_idx == MIX_MASTER;
    endsequence

    a_lineout_skip: assert property (s_master_wr and LINEOUT_UPDATE_DISABLE && !pend_r[P_LINE_OUT]
        |=> !pend_r[P_LINE_OUT]) else $error("line-out updated while disabled"); // R2
    a_alt_skip: assert property (s_master_wr and ALT_OUT_UPDATE_DISABLE && !pend_r[P_ALT_OUT]
        |=> !pend_r[P_ALT_OUT]) else $error("alternate updated while disabled"); // R3
    a_mono_skip: assert property (s_master_wr and MONO_OUT_UPDATE_DISABLE && !pend_r[P_MONO_OUT]
        |=> !pend_r[P_MONO_OUT]) else $error("mono updated while disabled"); // R4
    a_master_fanout: assert property (s_master_wr and !LINEOUT_UPDATE_DISABLE
        |=> pend_r[P_LINE_OUT] || (CODEC_WR_VALID && CODEC_WR.reg_addr == AC_LINE_OUT))
        else $error("master write not queued for line-out"); // R5
    a_codec_hold: assert property (CODEC_WR_VALID && !CODEC_WR_READY |=> $stable(CODEC_WR)
        && CODEC_WR_VALID) else $error("codec write dropped before acceptance"); // R23
    a_codec_sel: assert property ($rose(CODEC_WR_VALID) |-> CODEC_WR.secondary == $past(CODEC_SELECT))
        else $error("codec write sent to wrong codec"); // R1
    a_mute_both: assert property (CODEC_WR_VALID && CODEC_WR.reg_addr == AC_LINE_OUT
        && CODEC_WR.data[12:8] == 5'h1F && CODEC_WR.data[4:0] == 5'h1F |-> CODEC_WR.data[MUTE_B])
        else $error("mute bit missing for zero levels"); // R16
    a_id_read: assert property (VALUE_RD && dec_idx == MIX_ID |=> RDATA == MIX_ID_VALUE)
        else $error("identity index read wrong"); // R14
    a_high_read: assert property (VALUE_RD && dec_idx >= MIX_HIGH_BASE |=> RDATA == MIX_HIGH_VALUE)
        else $error("high index read wrong"); // R14
    a_stereo_order: assert property (SAMPLE_IN_VALID && half_r && STEREO_OUTPUT_FLAG
        |=> SAMPLE_OUT_VALID && SAMPLE_OUT.left == $past(SAMPLE_IN))
        else $error("second stereo byte not placed left"); // R20
    a_voice_map: assert property (VALUE_WR && !INDEX_WR && dec_idx == MIX_VOICE
        |=> PLAYBACK_LEVEL.left == $past(WDATA[7:5])) else $error("voice level not applied"); // R7

endmodule

//--- core/lmt_pkg.sv
/*
 * Constants and carrier types for the legacy mixer translator.
 * Assumes a single core clock domain and an AC-link register-write engine downstream.
 */
package lmt_pkg;

    // Mixer indices, after the alias bits are dropped.
    localparam logic [7:0] MIX_RESET_TRIGGER = 8'h00;
    localparam logic [7:0] MIX_VOICE         = 8'h04;
    localparam logic [7:0] MIX_MIC           = 8'h0A;
    localparam logic [7:0] MIX_INPUT         = 8'h0C;
    localparam logic [7:0] MIX_OUTPUT        = 8'h0E;
    localparam logic [7:0] MIX_ID            = 8'h20;
    localparam logic [7:0] MIX_MASTER        = 8'h22;
    localparam logic [7:0] MIX_SYNTH         = 8'h26;
    localparam logic [7:0] MIX_DISC          = 8'h28;
    localparam logic [7:0] MIX_LINE          = 8'h2E;
    localparam logic [7:0] MIX_ALIAS_MASK    = 8'hEE;
    localparam logic [7:0] MIX_HIGH_BASE     = 8'h40;
    localparam logic [7:0] MIX_ID_VALUE      = 8'h11;
    localparam logic [7:0] MIX_HIGH_VALUE    = 8'hFF;

    // Values loaded by reset and by the reset trigger.
    localparam logic [7:0] DEF_LOUD          = 8'h99;
    localparam logic [7:0] DEF_QUIET         = 8'h11;

    // Field positions inside a mixer byte; MUTE_B is bit 15 of a codec word.
    localparam int LEFT_HI   = 7;
    localparam int LEFT_LO   = 5;
    localparam int RIGHT_HI  = 3;
    localparam int RIGHT_LO  = 1;
    localparam int MIC_HI    = 2;
    localparam int MIC_LO    = 1;
    localparam int INSEL_HI  = 2;
    localparam int INSEL_LO  = 1;
    localparam int STEREO_B  = 1;
    localparam int MUTE_B    = 15;

    // Codec register indices.
    localparam logic [6:0] AC_LINE_OUT  = 7'h02;
    localparam logic [6:0] AC_ALT_OUT   = 7'h04;
    localparam logic [6:0] AC_MONO_OUT  = 7'h06;
    localparam logic [6:0] AC_MIC       = 7'h0E;
    localparam logic [6:0] AC_LINE_IN   = 7'h10;
    localparam logic [6:0] AC_DISC      = 7'h12;
    localparam logic [6:0] AC_REC_SEL   = 7'h1A;

    // Record-select words.
    localparam logic [15:0] REC_MIC  = 16'h0000;
    localparam logic [15:0] REC_DISC = 16'h0101;
    localparam logic [15:0] REC_LINE = 16'h0404;

    // Input-select codes.
    localparam logic [1:0] SEL_DISC = 2'h1;
    localparam logic [1:0] SEL_LINE = 2'h3;

    // Pending codec targets, one bit each.
    localparam int PEND_N     = 8;
    localparam int P_LINE_OUT = 0;
    localparam int P_ALT_OUT  = 1;
    localparam int P_MONO_OUT = 2;
    localparam int P_MIC      = 3;
    localparam int P_LINE_IN  = 4;
    localparam int P_DISC     = 5;
    localparam int P_REC_SEL  = 6;
    localparam int P_REC_VOL  = 7;

    typedef struct packed {
        logic        secondary;
        logic [6:0]  reg_addr;
        logic [15:0] data;
    } lmt_codec_wr_t;

    typedef struct packed {
        logic [2:0] left;
        logic [2:0] right;
    } lmt_level_pair_t;

    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
    } lmt_sample_t;

    typedef enum logic [0:0] {
        LS_IDLE = 1'b0,
        LS_BUSY = 1'b1
    } lmt_link_state_t;

endpackage

//--- test/lmt_codec_model.sv
/*
 * Codec register-write engine model at the far side of the translator.
 * Assumes the translator holds VALID and the write word until READY is seen high.
 */
`timescale 1ns/100ps
module lmt_codec_model (
    input  wire logic clk,
    input  wire logic rst,
    output logic      ready
);
    int seed = 32'h5A3;
    // Ready drops at random so that queued writes must wait their turn.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ready <= 1'b0;
        else
            ready <= ($random(seed) & 3) != 0;
    end
endmodule

//--- test/test_legacy_mixer_translator.sv
/*
 * Self-checking bench for the legacy mixer translator.
 * Assumes the codec model above and the default record volume register index.
 */
`timescale 1ns/100ps
module test_legacy_mixer_translator import lmt_pkg::*;;
    localparam logic [6:0] RV = 7'h1C;
    localparam logic [7:0] MT [8] = '{8'h1F, 8'h12, 8'h0E, 8'h0B, 8'h08, 8'h05, 8'h02, 8'h00};
    localparam logic [7:0] CT [8] = '{8'h1F, 8'h1A, 8'h16, 8'h13, 8'h10, 8'h0D, 8'h0A, 8'h08};
    localparam logic [7:0] MC [4] = '{8'h45, 8'h49, 8'h01, 8'h04};
    logic clk, rst, iwr, vwr, vrd, csel, dlo, dalt, dmono, cvalid, cready, siv, sov, sflag;
    logic [7:0] wd, rd, si, v, mst, mic, cd, ln, isel, idx;
    lmt_codec_wr_t cw;
    lmt_level_pair_t pl, sl;
    lmt_sample_t so;
    lmt_codec_wr_t q [$];
    int n_mismatch, total_checks, seed, i, k;
    lmt_top #(.REC_VOL_REG(RV)) dut (.CORE_CLK(clk), .RESET(rst), .INDEX_WR(iwr), .VALUE_WR(vwr),
        .VALUE_RD(vrd), .WDATA(wd), .RDATA(rd), .INDEX(idx), .CODEC_SELECT(csel),
        .LINEOUT_UPDATE_DISABLE(dlo), .ALT_OUT_UPDATE_DISABLE(dalt),
        .MONO_OUT_UPDATE_DISABLE(dmono), .CODEC_WR_VALID(cvalid), .CODEC_WR_READY(cready),
        .CODEC_WR(cw), .PLAYBACK_LEVEL(pl), .SYNTH_LEVEL(sl), .STEREO_OUTPUT_FLAG(sflag),
        .SAMPLE_IN_VALID(siv), .SAMPLE_IN(si), .SAMPLE_OUT_VALID(sov), .SAMPLE_OUT(so));
    lmt_codec_model partner (.clk(clk), .rst(rst), .ready(cready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] vw(input logic [7:0] x, input bit m);
        logic [15:0] w;
        w = m ? {MT[x[7:5]], MT[x[3:1]]} : {CT[x[7:5]], CT[x[3:1]]};
        w[15] = (x[7:5] == 3'h0) && (x[3:1] == 3'h0);
        return w;
    endfunction
    function automatic logic [15:0] recw();
        return isel[2:1] == 2'h1 ? vw(cd, 0) : isel[2:1] == 2'h3 ? vw(ln, 0) : {8'h00, MC[mic[2:1]]};
    endfunction
    task automatic chk_wr(input lmt_codec_wr_t e, input lmt_codec_wr_t s);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH codec_wr exp %h seen %h", e, s);
        end
    endtask
    task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Each accepted codec write is matched against the oldest expected one.
    always @(posedge clk)
    begin
        lmt_codec_wr_t e;
        e = '1;
        if (cvalid === 1'b1 && cready === 1'b1)
        begin
            if (q.size() != 0)
                e = q.pop_front();
            chk_wr(e, cw);
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk); iwr <= 1'b1; wd <= a;
        @(posedge clk); iwr <= 1'b0; vwr <= 1'b1; wd <= x;
        @(posedge clk); vwr <= 1'b0;
    endtask
    task automatic rdk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); iwr <= 1'b1; wd <= a;
        @(posedge clk); iwr <= 1'b0; vrd <= 1'b1;
        @(posedge clk); vrd <= 1'b0;
        @(posedge clk); chk_v("rdata", {8'h00, e}, {8'h00, rd});
        chk_v("index", {8'h00, a}, {8'h00, idx});
    endtask
    task automatic drain();
        int j;
        repeat (3) @(posedge clk);
        for (j = 0; j < 300 && (q.size() != 0 || cvalid !== 1'b0); j++)
        begin
            @(posedge clk); #1;
        end
        if (j == 300)
        begin
            n_mismatch++;
            close_out();
        end
    endtask
    initial
    begin
        #500000 n_mismatch++;
        close_out();
    end
    initial
    begin
        {iwr, vwr, vrd, csel, dlo, dalt, dmono, siv, wd, si} = '0;
        seed = 32'h81f9; rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        {mst, mic, cd, ln, isel} = {8'h99, 8'h11, 8'h11, 8'h11, 8'h11};
        rdk(8'h22, 8'h99); rdk(8'h30, 8'h11); rdk(8'h2A, 8'h11); rdk(8'h45, 8'hFF);
        $display("test readback done");
        for (i = 0; i < 16; i++)
        begin
            csel <= i[0]; dlo <= i[1]; dalt <= i[2]; dmono <= i[3];
            v = (i == 0) ? 8'h00 : $random(seed);
            mst = v;
            if (!i[1]) q.push_back({i[0], AC_LINE_OUT, vw(v, 1)});
            if (!i[2]) q.push_back({i[0], AC_ALT_OUT, vw(v, 1)});
            if (!i[3]) q.push_back({i[0], AC_MONO_OUT, (v[7:5] == 3'h0), 7'h00, MT[v[7:5]]});
            wr(8'h22, v); drain();
        end
        rdk(8'h32, mst);
        $display("test master done");
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed); v[2:1] = i[1:0]; isel = v;
            q.push_back({csel, AC_REC_SEL, i == 1 ? 16'h0101 : i == 3 ? 16'h0404 : 16'h0000});
            q.push_back({csel, RV, recw()});
            wr(8'h0C, v); drain();
        end
        for (k = 0; k < 6; k++)
        begin
            v = $random(seed);
            if (k % 3 == 0) cd = v; else if (k % 3 == 1) ln = v; else mic = v;
            q.push_back(k % 3 == 0 ? {csel, AC_DISC, vw(v, 0)} : k % 3 == 1 ?
                {csel, AC_LINE_IN, vw(v, 0)} : {csel, AC_MIC, 8'h00, MC[v[2:1]]});
            q.push_back({csel, RV, recw()});
            wr(k % 3 == 0 ? 8'h28 : k % 3 == 1 ? 8'h2E : 8'h0A, v); drain();
        end
        $display("test codec levels done");
        v = $random(seed); wr(8'h04, v); repeat (2) @(posedge clk);
        chk_v("playback", {10'h000, v[7:5], v[3:1]}, {10'h000, pl});
        v = $random(seed); wr(8'h26, v); repeat (2) @(posedge clk);
        chk_v("synth", {10'h000, v[7:5], v[3:1]}, {10'h000, sl});
        wr(8'h0E, 8'h02); drain();
        chk_v("stereo", 16'h0001, {15'h0000, sflag});
        @(posedge clk); siv <= 1'b1; si <= 8'h3C;
        @(posedge clk); si <= 8'hA5;
        @(posedge clk); siv <= 1'b0;
        for (i = 0; i < 4 && sov !== 1'b1; i++) @(posedge clk);
        chk_v("sample", 16'hA53C, so);
        wr(8'h0E, 8'h00); @(posedge clk); siv <= 1'b1; si <= 8'h5A;
        @(posedge clk); siv <= 1'b0;
        @(posedge clk); chk_v("mono", 16'h5A5A, so);
        chk_v("mono_valid", 16'h0001, {15'h0000, sov});
        $display("test internal and samples done");
        close_out();
    end
endmodule
